// [verilog/tcs_engine.v]
`include "tcs_map.vh"
`default_nettype none
module tcs_engine #(
  parameter NUM_DRIVES = 2,
  parameter START_TIMEOUT = 32'd50000000
)
(
  // clock and reset
  input wire clk,
  input wire reset_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // drive mechanism
  input wire cassette_in,
  input wire write_protect,
  input wire tape_moving,
  input wire at_tape_start_point,
  input wire at_tape_end_point,
  input wire erase_head_ok,
  input wire system_fault,
  input wire rw_active_read,
  input wire rw_active_write,
  output reg [1:0] drive_select,
  output reg motor_fwd,
  output reg motor_rev,
  output reg erase_on,
  // completion interrupt
  output reg done_irq
);
  localparam ST_IDLE = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_FWD = 3'd2;
  localparam ST_REW = 3'd3;
  localparam ST_DONE = 3'd4;

  reg [2:0] state;
  reg [7:0] op;
  reg [7:0] stat0;
  reg [7:0] stat1;
  reg [7:0] err_code;
  reg [1:0] stat_code;
  reg [15:0] data_err_cnt;
  reg [15:0] xrun_cnt;
  reg no_irq;
  reg drive_valid;
  reg [31:0] timer;
  reg [4:0] retry;
  reg [1:0] next_sel;

  wire wr_en = psel & penable & pwrite & ~pready;
  wire rd_en = psel & penable & ~pwrite & ~pready;
  wire go = wr_en && paddr == `TCS_CMD_ADDR && pwdata[`TCS_CMD_GO_BIT];
  wire [7:0] new_op = pwdata[7:0];
  wire [7:0] drv_num = pwdata[15:8];
  wire evt_wr = wr_en && paddr == `TCS_EVT_ADDR;
  wire busy = state != ST_IDLE;
  wire moving_op = state == ST_START || state == ST_FWD || state == ST_REW;
  // block-level events, written by the read/write engine through a port
  wire ev_data_err = evt_wr & pwdata[0];
  wire ev_xrun = evt_wr & pwdata[1];
  wire ev_block_fail = evt_wr & pwdata[2];
  wire ev_block_ok = evt_wr & pwdata[3];
  wire ev_fmark = evt_wr & pwdata[4] & rw_active_read;
  wire ev_gap = evt_wr & pwdata[5] & rw_active_read;
  wire ev_addr_lost = evt_wr & pwdata[6];
  wire ev_stored = evt_wr & pwdata[7];

  always @*
  begin
    next_sel = drive_select;
    if (drv_num == 8'h00)
      next_sel = 2'b01;
    else if (drv_num == 8'h01)
      next_sel = 2'b10;
  end

  // apb read data; one wait state in each access phase
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (rd_en)
      begin
        case (paddr)
          `TCS_CMD_ADDR: prdata <= {15'h0, no_irq, 8'h0, op};
          `TCS_CTRL_ADDR: prdata <= {22'h0, err_code, stat_code};
          `TCS_STAT0_ADDR: prdata <= {24'h0, stat0};
          `TCS_STAT1_ADDR: prdata <= {24'h0, stat1};
          `TCS_DERR_ADDR: prdata <= {16'h0, data_err_cnt};
          `TCS_XRUN_ADDR: prdata <= {16'h0, xrun_cnt};
          `TCS_EVT_ADDR: prdata <= {29'h0, state};
          `TCS_INFO_ADDR: prdata <= {30'h0, drive_select};
          default: pslverr <= 1'b1;
        endcase
      end
      else if (wr_en)
      begin
        case (paddr)
          `TCS_CMD_ADDR, `TCS_EVT_ADDR: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // command engine
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      op <= 8'h00;
      stat0 <= 8'h00;
      stat1 <= 8'h81;
      err_code <= 8'h00;
      stat_code <= `TCS_SC_DONE;
      data_err_cnt <= 16'h0;
      xrun_cnt <= 16'h0;
      no_irq <= 1'b0;
      drive_valid <= 1'b0;
      drive_select <= 2'b00;
      timer <= 32'h0;
      retry <= 5'd0;
      motor_fwd <= 1'b0;
      motor_rev <= 1'b0;
      erase_on <= 1'b0;
      done_irq <= 1'b0;
    end
    else
    begin
      done_irq <= 1'b0;
      stat1[`TCS_S1_BOM] <= at_tape_start_point & cassette_in;
      if (!drive_valid || !cassette_in)
        stat0[`TCS_S0_NOCAS] <= 1'b1;
      if (!drive_valid || !cassette_in || write_protect)
        stat0[`TCS_S0_WPROT] <= 1'b1;
      if (system_fault)
        stat1[`TCS_S1_FAULT] <= 1'b1;
      if (ev_data_err)
        data_err_cnt <= data_err_cnt + 16'h1;
      if (ev_xrun)
        xrun_cnt <= xrun_cnt + 16'h1;
      if (ev_block_ok)
        retry <= 5'd0;
      else if (ev_block_fail)
      begin
        retry <= retry + 5'd1;
        if (retry >= `TCS_RETRY_UNREC)
          stat0[`TCS_S0_UNREC] <= 1'b1;
        if (retry >= `TCS_RETRY_MARGIN && rw_active_write)
          stat1[`TCS_S1_MARGIN] <= 1'b1;
        if (retry >= `TCS_RETRY_UNREC && ev_addr_lost)
          stat0[`TCS_S0_NOBLK] <= 1'b1;
      end
      if (ev_stored)
        stat1[`TCS_S1_MARGIN] <= 1'b1;
      if (ev_fmark)
        stat0[`TCS_S0_FMARK] <= 1'b1;
      if (ev_gap)
        stat1[`TCS_S1_NODATA] <= 1'b1;

      if (go)
      begin
        op <= new_op;
        no_irq <= pwdata[`TCS_CMD_NOIRQ_BIT];
        err_code <= 8'h00;
        case (new_op)
          `TCS_OP_SELECT:
          begin
            if (busy || rw_active_write || rw_active_read ||
                drv_num > 8'h01 || system_fault)
            begin
              stat1[`TCS_S1_ILLEGAL] <= 1'b1;
              err_code[`TCS_EC_REJECT] <= 1'b1;
            end
            else if (drv_num >= NUM_DRIVES)
            begin
              stat0[`TCS_S0_UNSEL] <= 1'b1;
              err_code[`TCS_EC_REJECT] <= 1'b1;
            end
            else
            begin
              drive_select <= next_sel;
              drive_valid <= 1'b1;
              stat0[`TCS_S0_EOM] <= 1'b0;
            end
            state <= ST_DONE;
          end
          `TCS_OP_STATUS:
          begin
            // read clears power-on, unrecoverable, no-block and file-mark bits; summary bits clear only if no bit they follow was set
            stat0[`TCS_S0_UNREC] <= ev_block_fail & stat0[`TCS_S0_UNREC];
            stat0[`TCS_S0_NOBLK] <= 1'b0;
            stat0[`TCS_S0_FMARK] <= ev_fmark;
            stat1[`TCS_S1_POR] <= 1'b0;
            stat0[`TCS_S0_ERR] <= 1'b0;
            stat1[`TCS_S1_ERR] <= 1'b0;
            state <= ST_DONE;
          end
          `TCS_OP_REWIND, `TCS_OP_RETENSION, `TCS_OP_ERASE:
          begin
            if (!drive_valid || !cassette_in || system_fault || busy ||
                (new_op == `TCS_OP_ERASE &&
                 (write_protect || rw_active_read)))
            begin
              err_code[`TCS_EC_REJECT] <= 1'b1;
              if (!drive_valid)
                stat0[`TCS_S0_UNSEL] <= 1'b1;
              if (new_op == `TCS_OP_ERASE && rw_active_read)
                stat1[`TCS_S1_ILLEGAL] <= 1'b1;
              state <= ST_DONE;
            end
            else
            begin
              timer <= 32'h0;
              state <= ST_START;
              motor_fwd <= new_op != `TCS_OP_REWIND;
              motor_rev <= new_op == `TCS_OP_REWIND;
              erase_on <= new_op == `TCS_OP_ERASE;
              if (new_op != `TCS_OP_ERASE)
                stat0[`TCS_S0_EOM] <= 1'b0;
            end
          end
          default:
          begin
            stat1[`TCS_S1_ILLEGAL] <= 1'b1;
            err_code[`TCS_EC_REJECT] <= 1'b1;
            state <= ST_DONE;
          end
        endcase
        if (busy)
          state <= state;
        stat_code <= `TCS_SC_BUSY;
      end
      else
      begin
        case (state)
          ST_IDLE:
            timer <= 32'h0;
          ST_START:
          begin
            timer <= timer + 32'h1;
            if (tape_moving)
              state <= motor_fwd ? ST_FWD : ST_REW;
            else if (timer >= START_TIMEOUT - 32'h1)
            begin
              stat1[`TCS_S1_FAULT] <= 1'b1;
              err_code[`TCS_EC_ABORT] <= 1'b1;
              state <= ST_DONE;
            end
          end
          ST_FWD:
            if (at_tape_end_point)
            begin
              motor_fwd <= 1'b0;
              motor_rev <= 1'b1;
              erase_on <= 1'b0;
              state <= ST_REW;
            end
          ST_REW:
            if (at_tape_start_point)
            begin
              motor_rev <= 1'b0;
              state <= ST_DONE;
            end
          ST_DONE:
          begin
            motor_fwd <= 1'b0;
            motor_rev <= 1'b0;
            erase_on <= 1'b0;
            stat_code <= `TCS_SC_DONE;
            done_irq <= ~no_irq;
            state <= ST_IDLE;
          end
          default:
            state <= ST_IDLE;
        endcase
        // eject or erase head failure aborts
        if (moving_op && (!cassette_in ||
            (erase_on && !erase_head_ok)))
        begin
          if (!cassette_in)
            stat0[`TCS_S0_NOCAS] <= 1'b1;
          else
            stat1[`TCS_S1_FAULT] <= 1'b1;
          err_code[`TCS_EC_ABORT] <= 1'b1;
          motor_fwd <= 1'b0;
          motor_rev <= 1'b0;
          erase_on <= 1'b0;
          state <= ST_DONE;
        end
      end
      if (|stat0[6:0])
        stat0[`TCS_S0_ERR] <= 1'b1;
      // summary follows byte 1, leader bit excluded
      if (|{stat1[6:4], stat1[1:0]})
        stat1[`TCS_S1_ERR] <= 1'b1;
      // media end; set wins over a clear
      if ((rw_active_read | rw_active_write) & at_tape_start_point)
        stat0[`TCS_S0_EOM] <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [verilog/tcs_map.vh]
`ifndef TCS_MAP_VH
`define TCS_MAP_VH
// register byte addresses
`define TCS_CMD_ADDR 12'h000
`define TCS_CTRL_ADDR 12'h004
`define TCS_STAT0_ADDR 12'h008
`define TCS_STAT1_ADDR 12'h00c
`define TCS_DERR_ADDR 12'h010
`define TCS_XRUN_ADDR 12'h014
`define TCS_EVT_ADDR 12'h018
`define TCS_INFO_ADDR 12'h01c
// command codes
`define TCS_OP_SELECT 8'h01
`define TCS_OP_STATUS 8'hc1
`define TCS_OP_REWIND 8'h21
`define TCS_OP_ERASE 8'h22
`define TCS_OP_RETENSION 8'h24
// command register fields
`define TCS_CMD_GO_BIT 31
`define TCS_CMD_NOIRQ_BIT 16
// status byte 0 bits
`define TCS_S0_ERR 7
`define TCS_S0_NOCAS 6
`define TCS_S0_UNSEL 5
`define TCS_S0_WPROT 4
`define TCS_S0_EOM 3
`define TCS_S0_UNREC 2
`define TCS_S0_NOBLK 1
`define TCS_S0_FMARK 0
// status byte 1 bits
`define TCS_S1_ERR 7
`define TCS_S1_ILLEGAL 6
`define TCS_S1_NODATA 5
`define TCS_S1_MARGIN 4
`define TCS_S1_BOM 3
`define TCS_S1_FAULT 1
`define TCS_S1_POR 0
// error code bits
`define TCS_EC_REJECT 0
`define TCS_EC_ABORT 1
// status code values
`define TCS_SC_BUSY 2'b10
`define TCS_SC_DONE 2'b11
// retry limits
`define TCS_RETRY_UNREC 5'd16
`define TCS_RETRY_MARGIN 5'd8
`endif

// [test/tcs_engine_chk.sv]
`default_nettype none
module tcs_engine_chk (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // bus handshake
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // drive side
  input wire cassette_in,
  input wire [1:0] drive_select,
  input wire motor_fwd,
  input wire motor_rev,
  input wire erase_on,
  input wire done_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_taken;
    psel && penable && !pready;
  endsequence
  sequence s_halted;
    !motor_fwd && !motor_rev;
  endsequence
  a_access_answer: assert property (s_taken |=> pready)
    else $error("access not answered next cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held over one cycle");
  a_refuse_flag: assert property (pslverr |-> pready)
    else $error("error flag outside answer");
  a_select_onehot: assert property ($onehot0(drive_select))
    else $error("more than one drive selected");
  a_motor_excl: assert property (!(motor_fwd && motor_rev))
    else $error("both motor directions on");
  a_erase_fwd: assert property (erase_on |-> motor_fwd)
    else $error("erase head on without forward run");
  a_eject_stop: assert property ($fell(cassette_in) |-> ##[0:3] s_halted)
    else $error("tape still driven after eject");
  a_irq_pulse: assert property (done_irq |=> !done_irq)
    else $error("completion pulse too long");
  a_nodrive_idle: assert property (drive_select == 2'b00 |-> s_halted)
    else $error("motor runs with no drive selected");
endmodule
bind tcs_engine tcs_engine_chk tcs_engine_chk_i (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .cassette_in(cassette_in),
  .drive_select(drive_select), .motor_fwd(motor_fwd),
  .motor_rev(motor_rev), .erase_on(erase_on), .done_irq(done_irq));
`default_nettype wire

// [test/tcs_tape_model.sv]
`default_nettype none
module tcs_tape_model #(
  parameter int LEN = 12
) (
  // motor commands
  input wire logic clk,
  input wire logic motor_fwd,
  input wire logic motor_rev,
  input wire logic stuck,
  // tape sensors
  output var logic tape_moving,
  output logic at_start,
  output logic at_end
);
  timeunit 1ns;
  timeprecision 1ns;
  // starts mid-tape so a rewind has real distance to cover
  int pos = 3;
  initial tape_moving = 1'b0;
  // a stuck capstan never reports motion, forcing the start timeout
  always @(posedge clk)
  begin
    tape_moving <= (motor_fwd || motor_rev) && !stuck;
    if (tape_moving && motor_fwd && pos < LEN)
      pos <= pos + 1;
    else if (tape_moving && motor_rev && pos > 0)
      pos <= pos - 1;
  end
  assign at_start = (pos == 0);
  assign at_end = (pos == LEN);
endmodule
`default_nettype wire

// [test/test_tape_command_status_engine.sv]
`include "tcs_map.vh"
`default_nettype none
module test_tape_command_status_engine;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] op, drv; logic [31:0] ctrl; logic [1:0] sel;}
    tcs_row;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdata, prdata;
  logic pready, pslverr, serr, moving, at_start, at_end, mf, mr, ers, irq;
  logic cassette_in = 1, wprot = 0, stuck = 0, ehead_ok = 1, sfault = 0;
  logic rd_act = 0, wr_act = 0;
  logic [1:0] drive_select;
  int err_count = 0, compares = 0, irqs = 0, seen_end = 0, base;
  tcs_row rows[4] = '{
    '{`TCS_OP_REWIND, 8'h00, 32'h7, 2'b00},
    '{`TCS_OP_SELECT, 8'h02, 32'h7, 2'b00},
    '{`TCS_OP_SELECT, 8'h00, 32'h3, 2'b01},
    '{`TCS_OP_SELECT, 8'h01, 32'h3, 2'b10}};
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    if (irq === 1'b1)
      irqs++;
    if (at_end === 1'b1)
      seen_end = 1;
  end
  tcs_engine #(.START_TIMEOUT(32'd20)) tcs_engine_i (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cassette_in(cassette_in),
    .write_protect(wprot), .tape_moving(moving),
    .at_tape_start_point(at_start), .at_tape_end_point(at_end),
    .erase_head_ok(ehead_ok), .system_fault(sfault),
    .rw_active_read(rd_act), .rw_active_write(wr_act),
    .drive_select(drive_select), .motor_fwd(mf),
    .motor_rev(mr), .erase_on(ers), .done_irq(irq));
  tcs_tape_model tcs_tape_model_i (
    .clk(clk), .motor_fwd(mf), .motor_rev(mr), .stuck(stuck),
    .tape_moving(moving), .at_start(at_start), .at_end(at_end));
  task automatic give_verdict();
  begin
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  task automatic chk(input logic [31:0] got, exp);
  begin
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    int n;
  begin
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      err_count++;
      give_verdict();
    end
    @(posedge clk);
  end
  endtask
  // issue a command, then poll until the done code shows
  task automatic cmd(input logic [7:0] op, drv, input logic noirq);
    int n;
  begin
    n = 0;
    apb(1'b1, `TCS_CMD_ADDR, {1'b1, 14'h0, noirq, drv, op});
    do
    begin
      apb(1'b0, `TCS_CTRL_ADDR, 32'h0);
      n++;
    end
    while (rdata[1:0] !== 2'b11 && n < 200);
    if (rdata[1:0] !== 2'b11)
    begin
      err_count++;
      give_verdict();
    end
  end
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, `TCS_STAT1_ADDR, 32'h0);
    chk(rdata, 32'h81);
    apb(1'b0, `TCS_CTRL_ADDR, 32'h0);
    chk(rdata, 32'h3);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, serr}, 32'h1);
    foreach (rows[i])
    begin
      cmd(rows[i].op, rows[i].drv, 1'b0);
      chk(rdata, rows[i].ctrl);
      chk({30'h0, drive_select}, {30'h0, rows[i].sel});
    end
    cmd(`TCS_OP_STATUS, 8'h00, 1'b0);
    apb(1'b0, `TCS_STAT1_ADDR, 32'h0);
    chk(rdata, 32'hc0);
    apb(1'b1, `TCS_EVT_ADDR, 32'h1);
    apb(1'b1, `TCS_EVT_ADDR, 32'h1);
    apb(1'b1, `TCS_EVT_ADDR, 32'h2);
    apb(1'b0, `TCS_DERR_ADDR, 32'h0);
    chk(rdata, 32'h2);
    apb(1'b0, `TCS_XRUN_ADDR, 32'h0);
    chk(rdata, 32'h1);
    base = irqs;
    cmd(`TCS_OP_REWIND, 8'h00, 1'b0);
    chk(rdata, 32'h3);
    chk({31'h0, at_start}, 32'h1);
    chk(irqs - base, 1);
    apb(1'b0, `TCS_STAT1_ADDR, 32'h0);
    chk({31'h0, rdata[3]}, 32'h1);
    base = irqs;
    seen_end = 0;
    cmd(`TCS_OP_RETENSION, 8'h00, 1'b1);
    chk(rdata, 32'h3);
    chk(seen_end, 1);
    chk({31'h0, at_start}, 32'h1);
    chk(irqs - base, 0);
    wr_act <= 1'b1;
    repeat (17) apb(1'b1, `TCS_EVT_ADDR, 32'h4);
    apb(1'b1, `TCS_EVT_ADDR, 32'h44);
    wr_act <= 1'b0;
    apb(1'b0, `TCS_STAT1_ADDR, 32'h0);
    chk({31'h0, rdata[4]}, 32'h1);
    apb(1'b0, `TCS_STAT0_ADDR, 32'h0);
    chk({28'h0, rdata[3:0]}, 32'he);
    rd_act <= 1'b1;
    apb(1'b1, `TCS_EVT_ADDR, 32'h30);
    cmd(`TCS_OP_ERASE, 8'h00, 1'b0);
    chk(rdata, 32'h7);
    cmd(`TCS_OP_SELECT, 8'h01, 1'b0);
    chk(rdata, 32'h7);
    rd_act <= 1'b0;
    apb(1'b0, `TCS_STAT1_ADDR, 32'h0);
    chk({31'h0, rdata[5]}, 32'h1);
    apb(1'b0, `TCS_STAT0_ADDR, 32'h0);
    chk({31'h0, rdata[0]}, 32'h1);
    cmd(`TCS_OP_STATUS, 8'h00, 1'b0);
    apb(1'b0, `TCS_STAT0_ADDR, 32'h0);
    chk({28'h0, rdata[3:0]}, 32'h8);
    cmd(`TCS_OP_SELECT, 8'h01, 1'b0);
    chk(rdata, 32'h3);
    apb(1'b0, `TCS_STAT0_ADDR, 32'h0);
    chk({31'h0, rdata[3]}, 32'h0);
    seen_end = 0;
    apb(1'b1, `TCS_CMD_ADDR, {1'b1, 14'h0, 1'b1, 8'h00, `TCS_OP_RETENSION});
    cmd(`TCS_OP_SELECT, 8'h00, 1'b1);
    chk(rdata, 32'h7);
    chk(seen_end, 1);
    chk({30'h0, drive_select}, 32'h2);
    wprot <= 1'b1;
    cmd(`TCS_OP_ERASE, 8'h00, 1'b0);
    chk(rdata, 32'h7);
    wprot <= 1'b0;
    stuck <= 1'b1;
    cmd(`TCS_OP_ERASE, 8'h00, 1'b0);
    chk(rdata, 32'hb);
    apb(1'b0, `TCS_STAT1_ADDR, 32'h0);
    chk({31'h0, rdata[1]}, 32'h1);
    stuck <= 1'b0;
    sfault <= 1'b1;
    cmd(`TCS_OP_SELECT, 8'h00, 1'b0);
    chk(rdata, 32'h7);
    cmd(`TCS_OP_REWIND, 8'h00, 1'b0);
    chk(rdata, 32'h7);
    chk({30'h0, drive_select}, 32'h2);
    sfault <= 1'b0;
    ehead_ok <= 1'b0;
    cmd(`TCS_OP_ERASE, 8'h00, 1'b0);
    chk(rdata, 32'hb);
    ehead_ok <= 1'b1;
    fork
      cmd(`TCS_OP_RETENSION, 8'h00, 1'b0);
      begin
        repeat (9) @(posedge clk);
        cassette_in <= 1'b0;
      end
    join
    chk(rdata, 32'hb);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, `TCS_STAT1_ADDR, 32'h0);
    chk(rdata, 32'h81);
    chk({30'h0, drive_select}, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
